// [rtl/lsr_regs.sv]
// light sensor register bank behind the two-wire serial slave
// Notes on behaviour
// - every visible register is one 16-bit word, written msb byte first
// - pointers: result 00h, configuration 01h, low 02h, high 03h, id 7Eh
// - result holds latest finished conversion: exponent 15-12, mantissa 11-0
// - result is read-only and clears to zero on reset
// - mantissa is unsigned straight binary, zero to full scale
// - exponent codes 0 to 1011b name twelve binary-weighted ranges
// - mask set with manual range reads the result exponent as zero
// - configuration field layout is fixed as the package struct shows
// - all accesses arrive as transactions on the serial bus, device as slave
// - configuration write aborts a conversion and restarts when mode asks
// - range 1100b selects automatic range; 1101b-1111b are reserved
`timescale 1ns/10ps
`include "lsr_defines.svh"

module lsr_regs import lsr_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // serial pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output      logic        sda_out,
  output      logic        sda_oe,
  // conversion engine results
  input  wire logic        conv_done,
  input  wire logic [3:0]  conv_exp,
  input  wire logic [11:0] conv_mant,
  input  wire logic        conv_ovf,
  input  wire logic        hi_flag_in,
  input  wire logic        lo_flag_in,
  // settings and commands to the engine
  output      lsr_cfg_t    cfg_out,
  output      logic [15:0] low_limit_out,
  output      logic [15:0] high_limit_out,
  output      logic        conv_abort,
  output      logic        conv_start
);

  lsr_cfg_t    cfg_reg, cfg_next;
  logic [15:0] result_reg, result_next, low_reg, low_next, high_reg, high_next;
  logic [7:0]  ptr_reg, ptr_next, msb_reg, msb_next;
  logic        half_reg, half_next, abort_reg, abort_next, start_reg, start_next;
  logic [15:0] rd_word, wr_word;
  logic        commit;
  lsr_evt_t    evt;

  function automatic logic [3:0] exp_clamp(input logic [3:0] e);
    exp_clamp = (e > `LSR_EXP_MAX) ? `LSR_EXP_MAX : e;
  endfunction

  function automatic logic exp_masked(input lsr_cfg_t c);
    exp_masked = c.exponent_mask_enable && c.range_select < `LSR_RANGE_AUTO;
  endfunction

  // ****************************************
  // serial slave
  // ****************************************
  lsr_i2c_slave u_slave (
    .clk     (clk),
    .rst_n   (rst_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .rd_word (rd_word),
    .evt     (evt)
  );

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    case (ptr_reg)
      `LSR_OFS_RESULT: rd_word = {exp_masked(cfg_reg) ? 4'h0 : result_reg[15:12], result_reg[11:0]};
      `LSR_OFS_CFG:    rd_word = cfg_reg;
      `LSR_OFS_LOW:    rd_word = low_reg;
      `LSR_OFS_HIGH:   rd_word = high_reg;
      `LSR_OFS_ID:     rd_word = `LSR_MAKER_CODE;
      default:         rd_word = 16'h0000;
    endcase
  end

  // ****************************************
  // register updates
  // ****************************************
  always_comb begin
    wr_word     = {msb_reg, evt.data};
    commit      = evt.data_wr && half_reg;
    cfg_next    = cfg_reg;
    result_next = result_reg;
    low_next    = low_reg;
    high_next   = high_reg;
    ptr_next    = ptr_reg;
    msb_next    = msb_reg;
    half_next   = half_reg;
    abort_next  = 1'b0;
    start_next  = 1'b0;
    if (evt.gcall_rst) begin
      cfg_next    = lsr_cfg_t'(`LSR_CFG_RESET);
      result_next = 16'h0000;
      low_next    = `LSR_LOW_RESET;
      high_next   = `LSR_HIGH_RESET;
      half_next   = 1'b0;
    end else begin
      if (evt.ptr_wr) begin
        ptr_next  = evt.data;
        half_next = 1'b0;
      end
      if (evt.data_wr) begin
        half_next = ~half_reg;
        msb_next  = half_reg ? msb_reg : evt.data;
      end
      if (commit) begin
        case (ptr_reg)
          `LSR_OFS_CFG: begin
            // a reserved range code leaves the range unchanged
            if (wr_word[15:12] <= `LSR_RANGE_AUTO) begin
              cfg_next.range_select = wr_word[15:12];
            end
            cfg_next.conversion_time_select = wr_word[11];
            cfg_next.operating_mode_hi      = wr_word[10];
            cfg_next.operating_mode_lo      = wr_word[9];
            cfg_next.latch_enable           = wr_word[4];
            cfg_next.interrupt_polarity     = wr_word[3];
            cfg_next.exponent_mask_enable   = wr_word[2];
            cfg_next.fault_count_hi         = wr_word[1];
            cfg_next.fault_count_lo         = wr_word[0];
            abort_next = 1'b1;
            start_next = wr_word[10:9] != `LSR_MODE_OFF;
          end
          `LSR_OFS_LOW:  low_next  = wr_word;
          `LSR_OFS_HIGH: high_next = wr_word;
          default:       ; // result and id ignore writes
        endcase
      end
      cfg_next.high_limit_flag = hi_flag_in;
      cfg_next.low_limit_flag  = lo_flag_in;
      if (evt.rd_take && ptr_reg == `LSR_OFS_CFG) begin
        cfg_next.conversion_ready_flag = 1'b0;
      end
      // set after clear so a finishing conversion is not lost to a read in the same cycle; a general-call reset in that cycle drops it
      if (conv_done) begin
        result_next                    = {exp_clamp(conv_exp), conv_mant};
        cfg_next.conversion_ready_flag = 1'b1;
        cfg_next.overflow_flag         = conv_ovf;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg    <= lsr_cfg_t'(`LSR_CFG_RESET);
      result_reg <= 16'h0000;
      low_reg    <= `LSR_LOW_RESET;
      high_reg   <= `LSR_HIGH_RESET;
      ptr_reg    <= `LSR_OFS_RESULT;
      msb_reg    <= 8'h00;
      half_reg   <= 1'b0;
      abort_reg  <= 1'b0;
      start_reg  <= 1'b0;
    end else begin
      cfg_reg    <= cfg_next;
      result_reg <= result_next;
      low_reg    <= low_next;
      high_reg   <= high_next;
      ptr_reg    <= ptr_next;
      msb_reg    <= msb_next;
      half_reg   <= half_next;
      abort_reg  <= abort_next;
      start_reg  <= start_next;
    end
  end

  assign cfg_out        = cfg_reg;
  assign low_limit_out  = low_reg;
  assign high_limit_out = high_reg;
  assign conv_abort     = abort_reg;
  assign conv_start     = start_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_result_readonly: assert property (
    commit && ptr_reg == `LSR_OFS_RESULT && !conv_done |=> $stable(result_reg))
    else $error("result changed on host write");
  a_result_update: assert property (
    conv_done && !evt.gcall_rst |=> result_reg[11:0] == $past(conv_mant) &&
      result_reg[15:12] == exp_clamp($past(conv_exp)))
    else $error("result not loaded from conversion");
  a_exp_range: assert property (result_reg[15:12] <= `LSR_EXP_MAX)
    else $error("result exponent out of range");
  a_mask_zero: assert property (
    ptr_reg == `LSR_OFS_RESULT |-> rd_word[15:12] ==
      ((cfg_reg.exponent_mask_enable && cfg_reg.range_select != `LSR_RANGE_AUTO) ? 4'h0 : result_reg[15:12]))
    else $error("result exponent read wrong");
  a_cfg_abort: assert property (
    commit && ptr_reg == `LSR_OFS_CFG && !evt.gcall_rst |=> conv_abort ##1 !conv_abort)
    else $error("no abort pulse after configuration write");
  a_cfg_start: assert property (
    conv_start |-> conv_abort && cfg_reg.operating_mode_hi | cfg_reg.operating_mode_lo)
    else $error("start without configuration write or in shutdown");
  a_range_legal: assert property (cfg_reg.range_select <= `LSR_RANGE_AUTO)
    else $error("reserved range code stored");
  a_limit_write: assert property (
    commit && ptr_reg == `LSR_OFS_LOW && !evt.gcall_rst |=> low_reg == $past(wr_word))
    else $error("low limit not written");
  a_id_read: assert property (
    ptr_reg == `LSR_OFS_ID |-> rd_word == `LSR_MAKER_CODE)
    else $error("identification word wrong");
  a_ready_set: assert property (
    conv_done && !evt.gcall_rst |=> cfg_reg.conversion_ready_flag)
    else $error("ready flag not set");

endmodule // lsr_regs

// [rtl/lsr_defines.svh]
// constants for the light sensor register bank
`ifndef LSR_DEFINES_SVH
`define LSR_DEFINES_SVH

// ****************************************
// register pointers
// ****************************************
`define LSR_OFS_RESULT  8'h00
`define LSR_OFS_CFG     8'h01
`define LSR_OFS_LOW     8'h02
`define LSR_OFS_HIGH    8'h03
`define LSR_OFS_ID      8'h7e

// ****************************************
// reset values and field codes
// ****************************************
`define LSR_CFG_RESET   16'hc810
`define LSR_LOW_RESET   16'h0000
`define LSR_HIGH_RESET  16'hffff
`define LSR_RANGE_AUTO  4'hc
`define LSR_EXP_MAX     4'hb
`define LSR_MODE_OFF    2'h0
// arbitrary neutral identification value
`define LSR_MAKER_CODE  16'h5a5a

// ****************************************
// serial bus codes
// ****************************************
`define LSR_SLAVE_ADDR  7'h45
`define LSR_GCALL_ADDR  7'h00
`define LSR_GCALL_RESET 8'h06
`define LSR_BYTE_BITS   4'h8

`endif

// [rtl/lsr_pkg.sv]
// types for the light sensor register bank
package lsr_pkg;

  typedef struct packed {
    logic [3:0] range_select;
    logic       conversion_time_select;
    logic       operating_mode_hi;
    logic       operating_mode_lo;
    logic       overflow_flag;
    logic       conversion_ready_flag;
    logic       high_limit_flag;
    logic       low_limit_flag;
    logic       latch_enable;
    logic       interrupt_polarity;
    logic       exponent_mask_enable;
    logic       fault_count_hi;
    logic       fault_count_lo;
  } lsr_cfg_t;

  typedef struct packed {
    logic       ptr_wr;
    logic       data_wr;
    logic       gcall_rst;
    logic       rd_take;
    logic [7:0] data;
  } lsr_evt_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_RX   = 3'h2,
    ST_RACK = 3'h6,
    ST_TX   = 3'h7,
    ST_TACK = 3'h5
  } lsr_i2c_st_t;

endpackage

// [rtl/lsr_i2c_slave.sv]
// serial two-wire slave engine: 16-bit words in, byte events out
`timescale 1ns/10ps
`include "lsr_defines.svh"

module lsr_i2c_slave import lsr_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // serial pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output      logic        sda_out,
  output      logic        sda_oe,
  // register side
  input  wire logic [15:0] rd_word,
  output      lsr_evt_t    evt
);

  logic        scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  lsr_i2c_st_t st_reg, st_next;
  logic [15:0] sh_reg, sh_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic        rw_reg, rw_next, gc_reg, gc_next, first_reg, first_next;
  logic        oe_reg, oe_next;
  lsr_evt_t    evt_reg, evt_next;
  logic        rise, fall, start, stop;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  // ****************************************
  // bit and byte sequencing
  // ****************************************
  always_comb begin
    rise       = scl_s2 & ~scl_d;
    fall       = ~scl_s2 & scl_d;
    start      = scl_s2 & scl_d & sda_d & ~sda_s2;
    stop       = scl_s2 & scl_d & ~sda_d & sda_s2;
    st_next    = st_reg;
    sh_next    = sh_reg;
    cnt_next   = cnt_reg;
    rw_next    = rw_reg;
    gc_next    = gc_reg;
    first_next = first_reg;
    oe_next    = oe_reg;
    evt_next   = '0;
    if (start) begin
      st_next  = ST_ADDR;
      cnt_next = 4'h0;
      oe_next  = 1'b0;
    end else if (stop) begin
      st_next = ST_IDLE;
      oe_next = 1'b0;
    end else begin
      case (st_reg)
        ST_ADDR, ST_RX: begin
          if (rise) begin
            sh_next  = {sh_reg[14:0], sda_s2};
            cnt_next = cnt_reg + 4'h1;
          end else if (fall && cnt_reg == `LSR_BYTE_BITS) begin
            if (st_reg == ST_ADDR) begin
              if (sh_reg[7:1] == `LSR_SLAVE_ADDR || sh_reg[7:0] == {`LSR_GCALL_ADDR, 1'b0}) begin
                st_next    = ST_AACK;
                oe_next    = 1'b1;
                rw_next    = sh_reg[0];
                gc_next    = sh_reg[7:1] == `LSR_GCALL_ADDR;
                first_next = 1'b1;
              end else begin
                st_next = ST_IDLE;
              end
            end else if (gc_reg) begin
              // only the reset code is acknowledged on a general call
              evt_next.gcall_rst = sh_reg[7:0] == `LSR_GCALL_RESET;
              oe_next            = sh_reg[7:0] == `LSR_GCALL_RESET;
              st_next            = (sh_reg[7:0] == `LSR_GCALL_RESET) ? ST_RACK : ST_IDLE;
            end else begin
              evt_next.data    = sh_reg[7:0];
              evt_next.ptr_wr  = first_reg;
              evt_next.data_wr = ~first_reg;
              first_next       = 1'b0;
              oe_next          = 1'b1;
              st_next          = ST_RACK;
            end
          end
        end
        ST_AACK: begin
          if (fall) begin
            cnt_next = 4'h0;
            if (rw_reg) begin
              // word is captured once; later bytes rotate msb, lsb, msb...
              sh_next          = {rd_word[14:0], rd_word[15]};
              oe_next          = ~rd_word[15];
              evt_next.rd_take = 1'b1;
              st_next          = ST_TX;
            end else begin
              oe_next = 1'b0;
              st_next = ST_RX;
            end
          end
        end
        ST_RACK: begin
          if (fall) begin
            oe_next  = 1'b0;
            cnt_next = 4'h0;
            st_next  = ST_RX;
          end
        end
        ST_TX: begin
          if (rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (fall && cnt_reg == `LSR_BYTE_BITS) begin
            oe_next = 1'b0;
            st_next = ST_TACK;
          end else if (fall) begin
            oe_next = ~sh_reg[15];
            sh_next = {sh_reg[14:0], sh_reg[15]};
          end
        end
        ST_TACK: begin
          if (rise && sda_s2) begin
            st_next = ST_IDLE;
          end else if (fall) begin
            cnt_next = 4'h0;
            oe_next  = ~sh_reg[15];
            sh_next  = {sh_reg[14:0], sh_reg[15]};
            st_next  = ST_TX;
          end
        end
        default: begin
          st_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg    <= ST_IDLE;
      sh_reg    <= 16'h0000;
      cnt_reg   <= 4'h0;
      rw_reg    <= 1'b0;
      gc_reg    <= 1'b0;
      first_reg <= 1'b0;
      oe_reg    <= 1'b0;
      evt_reg   <= '0;
    end else begin
      st_reg    <= st_next;
      sh_reg    <= sh_next;
      cnt_reg   <= cnt_next;
      rw_reg    <= rw_next;
      gc_reg    <= gc_next;
      first_reg <= first_next;
      oe_reg    <= oe_next;
      evt_reg   <= evt_next;
    end
  end

  // open drain: the line is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe  = oe_reg;
  assign evt     = evt_reg;

endmodule // lsr_i2c_slave

// [tb/lsr_host_model.sv]
// serial bus master model that reaches the register bank
`timescale 1ns/10ps
`include "lsr_defines.svh"

module lsr_host_model (
  // clock
  input  wire logic clk,
  // serial pins
  input  wire logic sda,
  output      logic scl,
  output      logic sda_oe
);
  // half phase in clk cycles, kept well above the sampling minimum
  localparam int Q = 6;

  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // data only moves while scl is low; released line floats high on its pull-up
  task automatic bit_io(input logic b, output logic r);
    sda_oe <= ~b;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    r = sda;
    scl <= 1'b0;
    tick(Q);
  endtask

  task automatic start_c;
    sda_oe <= 1'b0;
    scl    <= 1'b1;
    tick(Q);
    sda_oe <= 1'b1;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask

  task automatic stop_c;
    sda_oe <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_oe <= 1'b0;
    tick(Q);
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask

  // whole word, msb byte first, in one write transaction
  task automatic wr_word(input logic [7:0] p, input logic [15:0] w, output logic ok);
    logic [3:0] a;
    start_c;
    put_byte({`LSR_SLAVE_ADDR, 1'b0}, a[0]);
    put_byte(p, a[1]);
    put_byte(w[15:8], a[2]);
    put_byte(w[7:0], a[3]);
    stop_c;
    ok = &a;
  endtask

  // pointer set by a partial write, then a two-byte read ended by nack
  task automatic rd_word(input logic [7:0] p, output logic [15:0] w, output logic ok);
    logic [2:0] a;
    start_c;
    put_byte({`LSR_SLAVE_ADDR, 1'b0}, a[0]);
    put_byte(p, a[1]);
    stop_c;
    start_c;
    put_byte({`LSR_SLAVE_ADDR, 1'b1}, a[2]);
    get_byte(1'b1, w[15:8]);
    get_byte(1'b0, w[7:0]);
    stop_c;
    ok = &a;
  endtask

  task automatic gcall(output logic ok);
    logic [1:0] a;
    start_c;
    put_byte({`LSR_GCALL_ADDR, 1'b0}, a[0]);
    put_byte(`LSR_GCALL_RESET, a[1]);
    stop_c;
    ok = &a;
  endtask

endmodule // lsr_host_model

// [tb/light_sensor_register_map_tb.sv]
// self-checking bench for the light sensor register bank
`timescale 1ns/10ps
`include "lsr_defines.svh"

`define CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) begin \
      n_fail++; \
      $display("BAD %s expected %h seen %h", nm, ex, got); \
    end \
  end

module light_sensor_register_map_tb import lsr_pkg::*; ();
  logic        clk, rst_n, conv_done, conv_ovf, hi_flag_in, lo_flag_in;
  logic [3:0]  conv_exp;
  logic [11:0] conv_mant;
  logic        scl, host_oe, dut_out, dut_oe, conv_abort, conv_start, ok;
  lsr_cfg_t    cfg_out;
  logic [15:0] low_limit_out, high_limit_out;
  int          n_fail, n_compared, n_ab, n_st;
  // open-drain wire with pull-up
  wire         sda = ~host_oe & (~dut_oe | dut_out);

  lsr_regs u_dut (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(dut_out), .sda_oe(dut_oe),
    .conv_done(conv_done), .conv_exp(conv_exp), .conv_mant(conv_mant), .conv_ovf(conv_ovf),
    .hi_flag_in(hi_flag_in), .lo_flag_in(lo_flag_in), .cfg_out(cfg_out),
    .low_limit_out(low_limit_out), .high_limit_out(high_limit_out),
    .conv_abort(conv_abort), .conv_start(conv_start)
  );

  lsr_host_model u_host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe));

  always #4 clk = ~clk;

  // pulses counted per cycle, so a stretched pulse shows as extra counts
  always @(posedge clk) begin
    if (conv_abort === 1'b1) n_ab++;
    if (conv_start === 1'b1) n_st++;
  end

  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] w);
    u_host.wr_word(p, w, ok);
    `CHK("write ack", 1'b1, ok)
  endtask

  task automatic rd(input logic [7:0] p, input logic [15:0] e);
    logic [15:0] w;
    u_host.rd_word(p, w, ok);
    `CHK("read ack", 1'b1, ok)
    `CHK("read word", e, w)
  endtask

  task automatic conv(input logic [3:0] e, input logic [11:0] m, input logic v);
    conv_exp  <= e;
    conv_mant <= m;
    conv_ovf  <= v;
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    @(posedge clk);
  endtask

  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    print_verdict;
  end

  initial begin
    clk = 1'b0; rst_n = 1'b0; conv_done = 1'b0; conv_ovf = 1'b0;
    hi_flag_in = 1'b0; lo_flag_in = 1'b0; conv_exp = 4'h0; conv_mant = 12'h000;
    n_fail = 0; n_compared = 0; n_ab = 0; n_st = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("cfg reset", `LSR_CFG_RESET, cfg_out)
    `CHK("low reset", `LSR_LOW_RESET, low_limit_out)
    `CHK("high reset", `LSR_HIGH_RESET, high_limit_out)
    rd(`LSR_OFS_RESULT, 16'h0000);
    rd(`LSR_OFS_CFG, `LSR_CFG_RESET);
    rd(`LSR_OFS_ID, `LSR_MAKER_CODE);
    wr(`LSR_OFS_LOW, 16'h1abc);
    wr(`LSR_OFS_HIGH, 16'hbfed);
    `CHK("low_limit_out", 16'h1abc, low_limit_out)
    `CHK("high_limit_out", 16'hbfed, high_limit_out)
    rd(`LSR_OFS_LOW, 16'h1abc);
    rd(`LSR_OFS_HIGH, 16'hbfed);
    conv(4'h3, 12'h456, 1'b0);
    rd(`LSR_OFS_RESULT, 16'h3456);
    conv(4'hb, 12'hfff, 1'b0);
    rd(`LSR_OFS_RESULT, 16'hbfff);
    // out-of-range exponent from the engine is clamped to the top range
    conv(4'hf, 12'h001, 1'b1);
    rd(`LSR_OFS_RESULT, 16'hb001);
    wr(`LSR_OFS_RESULT, 16'h1234);
    rd(`LSR_OFS_RESULT, 16'hb001);
    hi_flag_in <= 1'b1;
    rd(`LSR_OFS_CFG, `LSR_CFG_RESET | 16'h01c0);
    rd(`LSR_OFS_CFG, `LSR_CFG_RESET | 16'h0140);
    // manual range 3, continuous mode, mask on
    wr(`LSR_OFS_CFG, 16'h3415);
    `CHK("cfg_out", 16'h3555, cfg_out)
    `CHK("abort count", 1, n_ab)
    `CHK("start count", 1, n_st)
    rd(`LSR_OFS_CFG, 16'h3555);
    conv(4'h7, 12'h89a, 1'b0);
    rd(`LSR_OFS_RESULT, 16'h089a);
    // automatic range, mode off: exponent shown despite the mask
    wr(`LSR_OFS_CFG, 16'hc004);
    `CHK("abort count", 2, n_ab)
    `CHK("start count", 1, n_st)
    rd(`LSR_OFS_RESULT, 16'h789a);
    wr(`LSR_OFS_CFG, 16'hd21b);
    `CHK("cfg_out", 16'hc2db, cfg_out)
    `CHK("start count", 2, n_st)
    // low flag level mirrored into the configuration word
    lo_flag_in <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("cfg_out", 16'hc2fb, cfg_out)
    // host keeps to listed pointers: the read-only id word drops writes
    wr(`LSR_OFS_ID, 16'h1234);
    rd(`LSR_OFS_ID, `LSR_MAKER_CODE);
    `CHK("low_limit_out", 16'h1abc, low_limit_out)
    hi_flag_in <= 1'b0;
    lo_flag_in <= 1'b0;
    u_host.gcall(ok);
    `CHK("gcall ack", 1'b1, ok)
    repeat (4) @(posedge clk);
    `CHK("cfg reload", `LSR_CFG_RESET, cfg_out)
    `CHK("low reload", `LSR_LOW_RESET, low_limit_out)
    `CHK("high reload", `LSR_HIGH_RESET, high_limit_out)
    rd(`LSR_OFS_RESULT, 16'h0000);
    print_verdict;
  end

endmodule // light_sensor_register_map_tb
